// ### src/fcs_defines.svh
// Constants for the flash command sequencer host: command bytes, addresses, timings.
// Assumes a 50 MHz system clock; included by bare name.
`ifndef FCS_DEFINES_SVH
`define FCS_DEFINES_SVH

// ==========================================================
// Command bytes
`define FCS_CMD_READ 8'h00
`define FCS_CMD_SIG 8'h90
`define FCS_CMD_ERASE 8'h20
`define FCS_CMD_ERASE_VFY 8'hA0
`define FCS_CMD_PROG 8'h40
`define FCS_CMD_PROG_VFY 8'hC0
`define FCS_CMD_RESET 8'hFF

// ==========================================================
// Signature addresses
`define FCS_SIG_MFG_ADDR 17'h00000
`define FCS_SIG_DEV_ADDR 17'h00001

// ==========================================================
// Timing in ns, then cycle counts at 50 MHz
`define FCS_CLK_PERIOD_NS 20
`define FCS_WE_LOW_NS 40
`define FCS_WE_HIGH_NS 20
`define FCS_READ_ACCESS_NS 120
`define FCS_PROG_PULSE_NS 10000
`define FCS_ERASE_PULSE_NS 9500000
`define FCS_WRITE_RECOVERY_NS 6000
`define FCS_VPP_SETUP_NS 100
`define FCS_WE_LOW_CYC ((`FCS_WE_LOW_NS + `FCS_CLK_PERIOD_NS - 1) / `FCS_CLK_PERIOD_NS)
`define FCS_WE_HIGH_CYC ((`FCS_WE_HIGH_NS + `FCS_CLK_PERIOD_NS - 1) / `FCS_CLK_PERIOD_NS)
`define FCS_READ_CYC ((`FCS_READ_ACCESS_NS + `FCS_CLK_PERIOD_NS - 1) / `FCS_CLK_PERIOD_NS)
`define FCS_PROG_CYC ((`FCS_PROG_PULSE_NS + `FCS_CLK_PERIOD_NS - 1) / `FCS_CLK_PERIOD_NS)
`define FCS_ERASE_CYC ((`FCS_ERASE_PULSE_NS + `FCS_CLK_PERIOD_NS - 1) / `FCS_CLK_PERIOD_NS)
`define FCS_RECOVERY_CYC ((`FCS_WRITE_RECOVERY_NS + `FCS_CLK_PERIOD_NS - 1) / `FCS_CLK_PERIOD_NS)
`define FCS_VPP_SETUP_CYC ((`FCS_VPP_SETUP_NS + `FCS_CLK_PERIOD_NS - 1) / `FCS_CLK_PERIOD_NS)

`endif

// ### src/fcs_pkg.sv
// Types for the flash command sequencer host.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package fcs_pkg;
  // Operations the user may request
  typedef enum logic [2:0] {
    FCS_OP_READ,
    FCS_OP_SIG_MFG,
    FCS_OP_SIG_DEV,
    FCS_OP_ERASE,
    FCS_OP_ERASE_VFY,
    FCS_OP_PROGRAM,
    FCS_OP_PROG_VFY,
    FCS_OP_ABORT
  } fcs_op_type;
endpackage
`default_nettype wire

// ### src/fcs_host.sv
// Host controller that drives a byte-wide parallel flash through its pins.
// Assumes the flash pins are wired direct; the data bus is split into in/out/enable.
`timescale 1ns/10ps
`include "fcs_defines.svh"
`default_nettype none

module fcs_host #(
  parameter int ADDR_WIDTH = 17,
  parameter int ERASE_CYC = `FCS_ERASE_CYC,
  parameter int PROG_CYC = `FCS_PROG_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic reqValid,
  output logic reqReady,
  input wire fcs_pkg::fcs_op_type reqOp,
  input wire logic [ADDR_WIDTH-1:0] reqAddr,
  input wire logic [7:0] reqData,
  output logic rspValid,
  output logic [7:0] rspData,
  output logic [ADDR_WIDTH-1:0] flashAddr,
  output logic flashCeN,
  output logic flashOeN,
  output logic flashWeN,
  output logic flashVppHigh,
  input wire logic [7:0] flashDqIn,
  output logic [7:0] flashDqOut,
  output logic flashDqOe
);
  // ========================================================
  // Step sequencer
  typedef enum logic [1:0] {FCS_K_WRITE, FCS_K_READ, FCS_K_WAIT} fcs_kind_type;
  typedef enum {ST_IDLE, ST_VPP, ST_SETUP, ST_STROBE, ST_HOLD, ST_DONE} fcs_state_type;

  fcs_state_type state;
  fcs_pkg::fcs_op_type op;
  logic [2:0] step;
  logic [23:0] count;
  logic [ADDR_WIDTH-1:0] opAddr;
  logic [7:0] opData;
  logic [7:0] dqMeta;
  logic [7:0] dqSync;
  fcs_kind_type kind;
  logic [7:0] stepData;
  logic [ADDR_WIDTH-1:0] stepAddr;
  logic lastStep;
  logic [23:0] waitCyc;

  // Per-op step table: kind, data, address, and whether it ends the op
  always_comb begin
    kind = FCS_K_WRITE;
    stepData = `FCS_CMD_READ;
    stepAddr = opAddr;
    lastStep = 1'b0;
    waitCyc = 24'(`FCS_RECOVERY_CYC);
    unique case (op)
      fcs_pkg::FCS_OP_READ, fcs_pkg::FCS_OP_SIG_MFG, fcs_pkg::FCS_OP_SIG_DEV: begin
        stepData = (op == fcs_pkg::FCS_OP_READ) ? `FCS_CMD_READ : `FCS_CMD_SIG;
        if (op == fcs_pkg::FCS_OP_SIG_MFG) stepAddr = ADDR_WIDTH'(`FCS_SIG_MFG_ADDR);
        if (op == fcs_pkg::FCS_OP_SIG_DEV) stepAddr = ADDR_WIDTH'(`FCS_SIG_DEV_ADDR);
        if (step != 3'd0) begin
          kind = FCS_K_READ;
          lastStep = 1'b1;
        end
      end
      fcs_pkg::FCS_OP_ERASE: begin
        stepData = `FCS_CMD_ERASE;
        if (step == 3'd2) begin
          kind = FCS_K_WAIT;
          waitCyc = 24'(ERASE_CYC);
          lastStep = 1'b1;
        end
      end
      fcs_pkg::FCS_OP_ERASE_VFY: begin
        stepData = `FCS_CMD_ERASE_VFY;
        if (step != 3'd0) begin
          kind = FCS_K_READ;
          lastStep = 1'b1;
        end
      end
      fcs_pkg::FCS_OP_PROGRAM: begin
        unique case (step)
          3'd0: stepData = `FCS_CMD_PROG;
          3'd1: stepData = opData;
          3'd2: begin
            kind = FCS_K_WAIT;
            waitCyc = 24'(PROG_CYC);
          end
          3'd3: stepData = `FCS_CMD_PROG_VFY;
          default: begin
            kind = FCS_K_READ;
            lastStep = 1'b1;
          end
        endcase
      end
      fcs_pkg::FCS_OP_PROG_VFY: begin
        stepData = `FCS_CMD_PROG_VFY;
        if (step != 3'd0) begin
          kind = FCS_K_READ;
          lastStep = 1'b1;
        end
      end
      fcs_pkg::FCS_OP_ABORT: begin
        stepData = `FCS_CMD_RESET;
        lastStep = (step == 3'd1);
      end
    endcase
  end

  assign reqReady = (state == ST_IDLE);

  // Main sequencer; each write or read step: setup, strobe, hold/recovery; wait steps go setup then hold
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      op <= fcs_pkg::FCS_OP_READ;
      step <= 3'd0;
      count <= 24'h000000;
      opAddr <= '0;
      opData <= 8'h00;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (reqValid) begin
            op <= reqOp;
            opAddr <= reqAddr;
            opData <= reqData;
            step <= 3'd0;
            count <= 24'(`FCS_VPP_SETUP_CYC);
            state <= ST_VPP;
          end
        end
        ST_VPP: begin
          if (count <= 24'h000001) begin
            state <= ST_SETUP;
          end else begin
            count <= count - 24'h000001;
          end
        end
        ST_SETUP: begin
          if (kind == FCS_K_WAIT) begin
            count <= waitCyc;
            state <= ST_HOLD;
          end else begin
            count <= (kind == FCS_K_READ) ? 24'(`FCS_READ_CYC) : 24'(`FCS_WE_LOW_CYC);
            state <= ST_STROBE;
          end
        end
        ST_STROBE: begin
          if (count <= 24'h000001) begin
            count <= (kind == FCS_K_READ) ? 24'h000001 : 24'(`FCS_WE_HIGH_CYC);
            state <= ST_HOLD;
          end else begin
            count <= count - 24'h000001;
          end
        end
        ST_HOLD: begin
          if (count <= 24'h000001) begin
            if (lastStep) begin
              state <= ST_DONE;
            end else begin
              step <= step + 3'd1;
              state <= ST_SETUP;
            end
          end else begin
            count <= count - 24'h000001;
          end
        end
        ST_DONE: state <= ST_IDLE;
      endcase
    end
  end

  // ========================================================
  // Read data capture; bus pins come from outside the clock domain
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dqMeta <= 8'h00;
      dqSync <= 8'h00;
    end else begin
      dqMeta <= flashDqIn;
      dqSync <= dqMeta;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rspData <= 8'h00;
      rspValid <= 1'b0;
    end else begin
      rspValid <= (state == ST_HOLD) && (count <= 24'h000001) && lastStep;
      if (state == ST_HOLD && kind == FCS_K_READ) rspData <= dqSync;
    end
  end

  // ========================================================
  // Pin drive, all registered
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flashCeN <= 1'b1;
      flashOeN <= 1'b1;
      flashWeN <= 1'b1;
      flashVppHigh <= 1'b0;
      flashAddr <= '0;
      flashDqOut <= 8'h00;
      flashDqOe <= 1'b0;
    end else begin
      flashVppHigh <= (state != ST_IDLE) && (state != ST_DONE);
      // Chip select low only around a strobe; idle keeps the part in standby
      // Held through the write hold cycle so the strobe rise lands with the part selected
      flashCeN <= !(((state == ST_SETUP || state == ST_STROBE) && kind != FCS_K_WAIT)
        || (state == ST_HOLD && kind == FCS_K_WRITE));
      flashOeN <= !((state == ST_SETUP || state == ST_STROBE) && kind == FCS_K_READ);
      flashWeN <= !(state == ST_STROBE && kind == FCS_K_WRITE);
      if (state == ST_SETUP) begin
        flashAddr <= stepAddr;
        flashDqOut <= stepData;
      end
      // Data kept on the bus one cycle past the strobe rise for hold time
      flashDqOe <= (state == ST_SETUP || state == ST_STROBE || state == ST_HOLD)
        && kind == FCS_K_WRITE;
    end
  end

  // ========================================================
  // Checks
  // Strobe rises seen during an erase, so a lone erase write is caught at the pins
  logic weNDly;
  logic [1:0] eraseWrites;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      weNDly <= 1'b1;
      eraseWrites <= 2'h0;
    end else begin
      weNDly <= flashWeN;
      if (state == ST_IDLE) begin
        eraseWrites <= 2'h0;
      end else if (flashWeN && !weNDly && op == fcs_pkg::FCS_OP_ERASE) begin
        if (eraseWrites != 2'h3) begin
          eraseWrites <= eraseWrites + 2'h1;
        end
      end
    end
  end

  standby_idle_a: assert property (@(posedge clk) disable iff (!rstn)
    (state == ST_IDLE) |=> flashCeN && !flashDqOe) else $error("chip select active while idle");
  read_strobes_a: assert property (@(posedge clk) disable iff (!rstn)
    !flashOeN |-> flashWeN && !flashCeN && !flashDqOe) else $error("bad read strobes");
  write_vpp_a: assert property (@(posedge clk) disable iff (!rstn)
    $fell(flashWeN) |-> flashVppHigh && !flashCeN && flashDqOe) else $error("write without supply");
  data_stable_a: assert property (@(posedge clk) disable iff (!rstn)
    !flashWeN |=> $stable(flashDqOut) && $stable(flashAddr)) else $error("bus moved under strobe");
  erase_twice_a: assert property (@(posedge clk) disable iff (!rstn)
    (op == fcs_pkg::FCS_OP_ERASE && state == ST_HOLD && step == 3'd2) |-> eraseWrites == 2'h2)
    else $error("erase not doubled");
  abort_pair_a: assert property (@(posedge clk) disable iff (!rstn)
    (op == fcs_pkg::FCS_OP_ABORT && $rose(flashWeN)) |-> flashDqOut == `FCS_CMD_RESET)
    else $error("abort byte wrong");
  sig_addr_a: assert property (@(posedge clk) disable iff (!rstn)
    (op == fcs_pkg::FCS_OP_SIG_DEV && !flashOeN) |-> flashAddr == `FCS_SIG_DEV_ADDR)
    else $error("signature address wrong");
  prog_verify_a: assert property (@(posedge clk) disable iff (!rstn)
    (op == fcs_pkg::FCS_OP_PROGRAM && !flashOeN) |-> flashAddr == opAddr)
    else $error("verify address lost");
  ready_idle_a: assert property (@(posedge clk) disable iff (!rstn)
    rspValid |-> ##1 reqReady) else $error("not ready after answer");
endmodule

`default_nettype wire

// ### bench/fcs_flash_model.sv
// Behavioural model of the byte-wide flash device on the far side of the host pins.
// Assumes the testbench resolves the shared data bus from the host drive enable alone.
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Flash device model
module fcs_flash_model #(
  parameter logic [7:0] MFG_CODE = 8'h5A, // Arbitrary code
  parameter logic [7:0] DEV_CODE = 8'hC3 // Arbitrary code
) (
  input wire logic [16:0] addr,
  input wire logic ceN,
  input wire logic oeN,
  input wire logic weN,
  input wire logic vppHigh,
  input wire logic [7:0] dqIn,
  output logic [7:0] dqOut
);
  logic [7:0] mem [logic [16:0]];
  logic [7:0] cmd;
  logic [7:0] lastOut;
  logic [7:0] val;
  logic [16:0] latAddr;
  function automatic logic [7:0] rd(input logic [16:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  initial begin
    cmd = 8'h00;
    lastOut = 8'h00;
    latAddr = 17'h00000;
  end
  always @(negedge weN) if (!ceN) latAddr = addr;
  // Stop timers are not modelled: each pulse ends at the next strobe rise
  always @(posedge weN) if (!ceN && vppHigh) begin
    if (cmd == 8'h40) begin
      mem[latAddr] = dqIn;
      cmd = 8'h41;
    end else if (cmd == 8'h20 && dqIn == 8'h20) begin
      mem.delete();
      cmd = 8'h21;
    end else if (cmd == 8'hFF && dqIn == 8'hFF) cmd = 8'h00;
    else cmd = dqIn;
  end
  always @* begin
    case (cmd)
      8'h90: val = addr[0] ? DEV_CODE : MFG_CODE;
      8'hA0, 8'hC0: val = rd(latAddr);
      default: val = rd(addr);
    endcase
  end
  // Released bus shows the inverse, so a stale byte never passes
  always @* begin
    if (!ceN && !oeN && weN) begin
      dqOut = val;
      lastOut = val;
    end else dqOut = ~lastOut;
  end
endmodule
`default_nettype wire

// ### bench/test_flash_command_sequencer.sv
// Self-checking testbench of the flash command sequencer host.
// Assumes the flash model file and the design sources are compiled first.
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Testbench top
module test_flash_command_sequencer;
  localparam logic [7:0] MFG = 8'h5A; // Arbitrary code
  localparam logic [7:0] DEV = 8'hC3; // Arbitrary code
  logic clk, rstn, reqValid, reqReady, rspValid, ceN, oeN, weN, vpp, dqOe;
  fcs_pkg::fcs_op_type reqOp;
  logic [16:0] reqAddr, flashAddr, a;
  logic [7:0] reqData, rspData, hostDq, devDq, d, r;
  logic [7:0] expMem [logic [16:0]];
  int error_cnt, checks_done, seed, i;
  wire logic [7:0] busDq = dqOe ? hostDq : devDq;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  fcs_host #(.ERASE_CYC(20), .PROG_CYC(10)) u_fcs_host (.clk(clk), .rstn(rstn),
    .reqValid(reqValid), .reqReady(reqReady), .reqOp(reqOp), .reqAddr(reqAddr),
    .reqData(reqData), .rspValid(rspValid), .rspData(rspData), .flashAddr(flashAddr),
    .flashCeN(ceN), .flashOeN(oeN), .flashWeN(weN), .flashVppHigh(vpp),
    .flashDqIn(busDq), .flashDqOut(hostDq), .flashDqOe(dqOe));
  fcs_flash_model #(.MFG_CODE(MFG), .DEV_CODE(DEV)) u_fcs_flash_model (.addr(flashAddr),
    .ceN(ceN), .oeN(oeN), .weN(weN), .vppHigh(vpp), .dqIn(hostDq), .dqOut(devDq));
  // ==========================================================
  // Checking and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("error_cnt=%0d checks_done=%0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic logic [7:0] expByte(input logic [16:0] x);
    return expMem.exists(x) ? expMem[x] : 8'hFF;
  endfunction
  // One request, one answer; waits are bounded
  task automatic doOp(input fcs_pkg::fcs_op_type op, input logic [16:0] ad,
                      input logic [7:0] dt, output logic [7:0] rs);
    int n;
    n = 0;
    @(posedge clk);
    #2;
    while (reqReady !== 1'b1 && n < 4000) begin
      @(posedge clk);
      #2;
      n++;
    end
    reqValid = 1'b1;
    reqOp = op;
    reqAddr = ad;
    reqData = dt;
    @(posedge clk);
    #2;
    reqValid = 1'b0;
    n = 0;
    while (rspValid !== 1'b1 && n < 4000) begin
      @(posedge clk);
      #2;
      n++;
    end
    check(rspValid, 1'b1);
    rs = rspData;
    @(posedge clk);
    #2;
    check(ceN, 1'b1);
  endtask
  // Pin-level watchers
  always @(negedge weN) check(vpp, 1'b1);
  always @(negedge oeN) check(weN, 1'b1);
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end
  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'he66e;
    error_cnt = 0;
    checks_done = 0;
    rstn = 1'b0;
    reqValid = 1'b0;
    reqOp = fcs_pkg::FCS_OP_READ;
    reqAddr = 17'h00000;
    reqData = 8'h00;
    repeat (16) @(posedge clk);
    #2 rstn = 1'b1;
    check(dqOe, 1'b0);
    check(u_fcs_flash_model.cmd, 8'h00);
    doOp(fcs_pkg::FCS_OP_SIG_MFG, 17'h00000, 8'h00, r);
    check(r, MFG);
    doOp(fcs_pkg::FCS_OP_SIG_DEV, 17'h00000, 8'h00, r);
    check(r, DEV);
    for (i = 0; i < 6; i++) begin
      a = (i == 0) ? 17'h00000 : (i == 1) ? 17'h1FFFF : 17'($random(seed));
      d = 8'($random(seed));
      expMem[a] = d;
      doOp(fcs_pkg::FCS_OP_PROGRAM, a, d, r);
      check(r, d);
      doOp(fcs_pkg::FCS_OP_READ, a, 8'h00, r);
      check(r, expByte(a));
      doOp(fcs_pkg::FCS_OP_PROG_VFY, a, 8'h00, r);
      check(r, d);
    end
    doOp(fcs_pkg::FCS_OP_ERASE, 17'h00000, 8'h00, r);
    expMem.delete();
    check(u_fcs_flash_model.cmd, 8'h21);
    for (i = 0; i < 2; i++) begin
      a = i ? 17'h1FFFF : 17'h00000;
      doOp(fcs_pkg::FCS_OP_ERASE_VFY, a, 8'h00, r);
      check(r, expByte(a));
    end
    doOp(fcs_pkg::FCS_OP_ERASE, 17'h00000, 8'h00, r);
    doOp(fcs_pkg::FCS_OP_ABORT, 17'h00000, 8'h00, r);
    check(u_fcs_flash_model.cmd, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
